// *** logic/lldram_device.sv ***
// lldram_device.sv: command, burst, refresh and termination logic of the memory device
// assumes: link pins are asynchronous to clk_sys; AXI4-Lite master on clk_sys
//
// The address map and the AXI4-Lite slave port are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
`include "lldram_consts.svh"
module lldram_device (
    input  wire logic        clk_sys,
    input  wire logic        reset,
    input  wire logic        ck,
    input  wire logic        chip_sel_n,
    input  wire logic        write_en_n,
    input  wire logic        refresh_n,
    input  wire logic [2:0]  bank,
    input  wire logic [19:0] addr,
    input  wire logic [17:0] write_data,
    input  wire logic        write_beat_mask,
    input  wire logic        write_data_strobe,
    output logic      [17:0] read_data,
    output logic             read_data_oe_n,
    output logic      [1:0]  read_data_strobe,
    output logic             read_valid_flag,
    output logic             input_termination,
    input  wire logic [3:0]  awaddr,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    output logic      [1:0]  bresp,
    output logic             bvalid,
    input  wire logic        bready,
    input  wire logic [3:0]  araddr,
    input  wire logic        arvalid,
    output logic             arready,
    output logic      [31:0] rdata,
    output logic      [1:0]  rresp,
    output logic             rvalid,
    input  wire logic        rready
);
    default clocking dc @(posedge clk_sys);
    endclocking
    default disable iff (reset);

    logic [`PIN_W-1:0] pins;
    logic              ck_s;
    logic              cs_n_s;
    logic              we_n_s;
    logic              ref_n_s;
    logic [2:0]        bank_s;
    logic [19:0]       addr_s;
    logic [17:0]       d_s;
    logic              mask_s;
    logic              dk_s;

    pin_sync #(.W(`PIN_W)) u_sync (
        .clk_sys (clk_sys),
        .reset   (reset),
        .raw     ({ck, chip_sel_n, write_en_n, refresh_n, bank, addr, write_data,
                   write_beat_mask, write_data_strobe}),
        .stable  (pins)
    );
    assign {ck_s, cs_n_s, we_n_s, ref_n_s, bank_s, addr_s, d_s, mask_s, dk_s} = pins;

    // edges of the command clock and write strobe
    logic ck_d;
    logic dk_d;
    logic ck_rise;
    logic ck_fall;
    logic ck_edge;
    logic dk_rise;
    logic dk_edge;

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            ck_d <= 1'b0;
            dk_d <= 1'b0;
        end else begin
            ck_d <= ck_s;
            dk_d <= dk_s;
        end
    end

    assign ck_rise = ck_s & ~ck_d;
    assign ck_fall = ~ck_s & ck_d;
    assign ck_edge = ck_rise | ck_fall;
    assign dk_rise = dk_s & ~dk_d;
    assign dk_edge = dk_s ^ dk_d;

    // command decode and two-part address assembly
    lldram_pkg::cmd_t  cmd;
    lldram_pkg::cmd_t  pend_cmd;
    lldram_pkg::cmd_t  go_cmd;
    logic              mux_pend;
    logic [10:0]       pend_ax;
    logic [2:0]        pend_bank;
    logic [2:0]        go_bank;
    logic [19:0]       go_addr;
    logic              rd_go;
    logic              wr_go;
    logic              ref_go;
    logic              cfg_go;
    logic              term_en;
    logic              mux_en;
    logic [1:0]        bl_code;
    logic [3:0]        bl_beats;

    always_comb begin
        cmd = lldram_pkg::cmd_none;
        if (!cs_n_s) begin
            unique case ({we_n_s, ref_n_s})
                2'h3: cmd = lldram_pkg::cmd_read;
                2'h1: cmd = lldram_pkg::cmd_write;
                2'h2: cmd = lldram_pkg::cmd_refresh;
                2'h0: cmd = lldram_pkg::cmd_config;
            endcase
        end
    end

    always_comb begin
        go_cmd  = lldram_pkg::cmd_none;
        go_addr = addr_s;
        go_bank = bank_s;
        if (ck_rise && mux_pend) begin
            go_cmd  = pend_cmd;                           // [R19]
            go_addr = {addr_s[`AY_PART], pend_ax};
            go_bank = pend_bank;                          // [R20]
        end else if (ck_rise && (!mux_en || cmd == lldram_pkg::cmd_refresh)) begin
            go_cmd = cmd;                                 // [R25] [R1] [R6] [R24]
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            mux_pend  <= 1'b0;
            pend_cmd  <= lldram_pkg::cmd_none;
            pend_ax   <= 11'h000;
            pend_bank <= 3'h0;
        end else if (ck_rise) begin
            // first part of a multiplexed command waits for its second edge
            mux_pend <= !mux_pend && mux_en && cmd != lldram_pkg::cmd_none
                        && cmd != lldram_pkg::cmd_refresh;  // [R19] [R21]
            if (!mux_pend) begin
                pend_cmd  <= cmd;
                pend_ax   <= addr_s[`AX_PART];
                pend_bank <= bank_s;                      // [R20]
            end
        end
    end

    assign rd_go  = go_cmd == lldram_pkg::cmd_read;
    assign wr_go  = go_cmd == lldram_pkg::cmd_write;
    assign ref_go = go_cmd == lldram_pkg::cmd_refresh;
    assign cfg_go = go_cmd == lldram_pkg::cmd_config;

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            term_en <= 1'b0;
            mux_en  <= 1'b0;
            bl_code <= 2'h0;
        end else if (cfg_go) begin
            term_en <= go_addr[`MR_TERM];                 // [R17]
            mux_en  <= go_addr[`MR_MUX];                  // [R21]
            bl_code <= go_addr[`MR_BL];
        end
    end

    always_comb begin
        unique case (bl_code)
            2'h0:    bl_beats = `BEATS_2;
            2'h1:    bl_beats = `BEATS_4;
            default: bl_beats = `BEATS_8;
        endcase
    end

    // latency pipelines, one slot per command clock
    logic [6:0]            ctrl;
    logic [3:0]            rl_base;
    logic [3:0]            rd_ins;
    logic [3:0]            wr_ins;
    logic [`PIPE_N-1:0]    rq_v;
    logic [`PIPE_N-1:0]    wq_v;
    logic [`MEM_AW-1:0]    rq_a [`PIPE_N];
    logic [`MEM_AW-1:0]    wq_a [`PIPE_N];
    logic [`MEM_AW-1:0]    go_loc;

    assign rl_base = ctrl[`CTRL_RL];
    // multiplexed commands run one edge late and latency grows by one,
    // so the slot index is the same in both modes
    assign rd_ins  = (rl_base == 4'h0) ? 4'h0 : rl_base - 4'h1;  // [R8] [R23]
    assign wr_ins  = rd_ins + 4'h1;                               // [R3] [R23]
    assign go_loc  = {go_bank, go_addr[`COL_BITS]};

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            rq_v <= {`PIPE_N{1'b0}};
            wq_v <= {`PIPE_N{1'b0}};
        end else if (ck_rise) begin
            // independent queues: reads and writes sequence freely
            rq_v <= rq_v >> 1;                            // [R4] [R13]
            wq_v <= wq_v >> 1;
            if (rd_go) begin
                rq_v[rd_ins] <= 1'b1;
            end
            if (wr_go) begin
                wq_v[wr_ins] <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (ck_rise) begin
            for (int i = 0; i < `PIPE_N - 1; i++) begin
                rq_a[i] <= rq_a[i+1];
                wq_a[i] <= wq_a[i+1];
            end
            if (rd_go) begin
                rq_a[rd_ins] <= go_loc;
            end
            if (wr_go) begin
                wq_a[wr_ins] <= go_loc;
            end
        end
    end

    // write burst capture on both strobe edges
    logic [17:0]        mem [`MEM_WORDS];
    logic               wr_armed;
    logic               wr_act;
    logic               cap;
    logic               mem_we;
    logic [3:0]         wr_left;
    logic [`MEM_AW-1:0] wr_a;

    assign cap    = dk_edge && (wr_act || (wr_armed && dk_rise));  // [R2] [R3]
    assign mem_we = cap && !mask_s;                                // [R5]

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            wr_armed <= 1'b0;
            wr_act   <= 1'b0;
            wr_left  <= 4'h0;
            wr_a     <= 8'h00;
        end else if (ck_rise && wq_v[0]) begin
            wr_armed <= 1'b1;
            wr_act   <= 1'b0;
            wr_a     <= wq_a[0];
            wr_left  <= bl_beats;
        end else if (cap) begin
            wr_armed <= 1'b0;
            wr_act   <= wr_left != 4'h1;
            wr_left  <= wr_left - 4'h1;
            wr_a     <= wr_a + `LOC_STEP;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (mem_we) begin
            mem[wr_a] <= d_s;
        end
    end

    // read burst output on both clock edges
    logic [3:0]         rd_left;
    logic [3:0]         next_rd_left;
    logic [`MEM_AW-1:0] rd_a;
    logic               rd_fire;

    assign rd_fire = ck_rise && rq_v[0];

    always_comb begin
        next_rd_left = rd_left;
        if (rd_fire) begin
            next_rd_left = bl_beats - 4'h1;
        end else if (ck_edge && rd_left != 4'h0) begin
            next_rd_left = rd_left - 4'h1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            read_data      <= 18'h00000;
            read_data_oe_n <= 1'b1;
            rd_left        <= 4'h0;
            rd_a           <= 8'h00;
        end else begin
            rd_left <= next_rd_left;
            if (rd_fire) begin
                // a new burst takes over at once, so back-to-back reads stream
                read_data      <= mem[rq_a[0]];          // [R8] [R12]
                read_data_oe_n <= 1'b0;
                rd_a           <= rq_a[0] + `LOC_STEP;
            end else if (ck_edge && rd_left != 4'h0) begin
                read_data <= mem[rd_a];                  // [R7]
                rd_a      <= rd_a + `LOC_STEP;
            end else if (ck_edge) begin
                read_data_oe_n <= 1'b1;                  // [R11]
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            read_valid_flag <= 1'b0;
        end else if (ck_edge) begin
            read_valid_flag <= next_rd_left != 4'h0 || (ck_fall && rq_v[0]);  // [R9]
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            read_data_strobe <= 2'h0;
        end else begin
            read_data_strobe <= {2{ck_s}};               // [R7] [R10]
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            input_termination <= 1'b0;
        end else begin
            input_termination <= term_en && rq_v == {`PIPE_N{1'b0}}
                                 && read_data_oe_n && !rd_fire;  // [R17] [R18]
        end
    end

    // per-bank refresh row counters
    logic [`ROW_W-1:0] row_cnt [`BANKS];

    generate
        for (genvar b = 0; b < `BANKS; b++) begin : g_bank
            always_ff @(posedge clk_sys) begin
                if (reset) begin
                    row_cnt[b] <= {`ROW_W{1'b0}};
                end else if (ref_go && go_bank == 3'(b)) begin
                    row_cnt[b] <= row_cnt[b] + `ROW_STEP;  // [R14]
                end
            end
        end
    endgenerate

    // register slave
    logic [3:0]  aw_a;
    logic [31:0] w_d;
    logic [3:0]  w_s;
    logic        wr_now;
    logic [31:0] status;

    assign wr_now = !awready && !wready && !bvalid;
    assign status = {3'h0, row_cnt[ctrl[`CTRL_BANK]], 10'h000, !read_data_oe_n,
                     mux_pend, mux_en, term_en, bl_code};

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            awready <= 1'b1;
            wready  <= 1'b1;
            bvalid  <= 1'b0;
            bresp   <= `RESP_OKAY;
            aw_a    <= 4'h0;
            w_d     <= 32'h00000000;
            w_s     <= 4'h0;
        end else begin
            if (awvalid && awready) begin
                awready <= 1'b0;
                aw_a    <= awaddr;
            end
            if (wvalid && wready) begin
                wready <= 1'b0;
                w_d    <= wdata;
                w_s    <= wstrb;
            end
            if (wr_now) begin
                bvalid <= 1'b1;
                bresp  <= (aw_a == `REG_CTRL || aw_a == `REG_STATUS) ? `RESP_OKAY : `RESP_SLVERR;
            end
            if (bvalid && bready) begin
                bvalid  <= 1'b0;
                awready <= 1'b1;
                wready  <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            ctrl <= `CTRL_RESET;
        end else if (wr_now && aw_a == `REG_CTRL && w_s[0]) begin
            ctrl <= w_d[6:0];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            arready <= 1'b1;
            rvalid  <= 1'b0;
            rdata   <= 32'h00000000;
            rresp   <= `RESP_OKAY;
        end else if (arvalid && arready) begin
            arready <= 1'b0;
            rvalid  <= 1'b1;
            rresp   <= `RESP_OKAY;
            if (araddr == `REG_CTRL) begin
                rdata <= {25'h0000000, ctrl};
            end else if (araddr == `REG_STATUS) begin
                rdata <= status;
            end else begin
                rdata <= 32'h00000000;
                rresp <= `RESP_SLVERR;
            end
        end else if (rvalid && rready) begin
            rvalid  <= 1'b0;
            arready <= 1'b1;
        end
    end

    // checks
    hiz_end_a: assert property ((ck_edge && rd_left == 4'h0 && !rd_fire) |=> read_data_oe_n)  // [R11]
        else $error("read outputs still driven after burst");
    valid_lead_a: assert property ($rose(read_valid_flag) |-> ##[1:8] !read_data_oe_n)  // [R9]
        else $error("valid flag not followed by data");
    term_off_a: assert property (!read_data_oe_n |-> !input_termination)  // [R18]
        else $error("termination on while driving reads");
    data_edge_a: assert property ($changed(read_data) |-> $changed(read_data_strobe[0]))  // [R7]
        else $error("read data moved off a strobe edge");
    strobe_pair_a: assert property (read_data_strobe[0] == read_data_strobe[1])  // [R10]
        else $error("read strobes disagree");
    rd_slot_a: assert property (rd_go |=> rq_v[$past(rd_ins)])  // [R8]
        else $error("read not queued at its latency");
    wr_slot_a: assert property (wr_go |=> wq_v[$past(wr_ins)] && $past(wr_ins) == $past(rd_ins) + 4'h1)  // [R3]
        else $error("write not queued at read latency plus one");
    mask_store_a: assert property (mem_we |-> dk_edge && !mask_s)  // [R5]
        else $error("masked or off-edge beat stored");
    mux_cfg_a: assert property (cfg_go |=> mux_en == $past(go_addr[`MR_MUX]))  // [R21]
        else $error("multiplexed mode not taken from config load");
    mux_wait_a: assert property ((ck_rise && mux_pend) |-> !(ck_rise && cmd == lldram_pkg::cmd_none
        && pend_cmd == lldram_pkg::cmd_none))  // [R19]
        else $error("second address part with no command held");

    rd_burst_c: cover property (rd_fire ##[1:60] rd_fire);
    wr_beat_c: cover property (mem_we);
    refresh_c: cover property (ref_go);
    mux_cmd_c: cover property (mux_pend && rd_go);
endmodule
`default_nettype wire

// *** logic/lldram_consts.svh ***
// lldram_consts.svh: offsets, field positions, codes and counts of the memory device
// assumes: included by lldram_device only; pin_sync and lldram_pkg do not include it
// How it works
// [R1] write takes row and bank with command
// [R2] write beats land on both strobe edges
// [R3] write delay is read delay plus one
// [R4] read may follow any write burst
// [R5] masked beat is not stored
// [R6] read takes row and bank with command
// [R7] read data moves on both strobe edges
// [R8] read data follows programmed read delay
// [R9] valid flag leads data by half cycle
// [R10] strobe 0 low nine, strobe 1 high nine
// [R11] outputs float after burst ends
// [R12] back-to-back reads stream without gaps
// [R13] write may follow any read burst
// [R14] refresh row from per-bank counter
// [R15] controller waits bank cycle after refresh (the controller model waits BANK_CYCLE clocks only when not multiplexed)
// [R16] controller refreshes every row each 32 ms (the controller model refreshes only when the bench calls its refresh task)
// [R17] config address bit 9 enables termination
// [R18] termination off around read bursts
// [R19] multiplexed address comes in two parts
// [R20] bank arrives with command, first part
// [R21] config address bit 5 enters multiplexed mode
// [R22] controller drives address 10..17 low on config
// [R23] multiplexed mode adds one latency cycle
// [R24] multiplexed refresh frees next clock
// [R25] commands sampled on clock rising edge
`ifndef LLDRAM_CONSTS_SVH
`define LLDRAM_CONSTS_SVH
`define REG_CTRL    4'h0
`define REG_STATUS  4'h4
`define CTRL_RESET  7'h04
`define CTRL_RL     3:0
`define CTRL_BANK   6:4
`define MR_TERM     9
`define MR_MUX      5
`define MR_BL       4:3
`define AX_PART     10:0
`define AY_PART     8:0
`define COL_BITS    4:0
`define MEM_AW      8
`define MEM_WORDS   256
`define LOC_STEP    8'h01
`define ROW_W       13
`define ROW_STEP    13'h0001
`define BANKS       8
`define PIPE_N      16
`define PIN_W       47
`define BEATS_2     4'h2
`define BEATS_4     4'h4
`define BEATS_8     4'h8
`define RESP_OKAY   2'h0
`define RESP_SLVERR 2'h2
`endif

// *** logic/lldram_pkg.sv ***
// lldram_pkg.sv: types shared by the memory device
// assumes: nothing beyond the compiler
`default_nettype none
package lldram_pkg;
    typedef enum logic [4:0] {
        cmd_none    = 5'h01,
        cmd_read    = 5'h02,
        cmd_write   = 5'h04,
        cmd_refresh = 5'h08,
        cmd_config  = 5'h10
    } cmd_t;
endpackage
`default_nettype wire

// *** logic/pin_sync.sv ***
// pin_sync.sv: three-stage synchroniser for pins from outside clk_sys
// assumes: a change is taken once stages two and three agree
`timescale 1ns/10ps
`default_nettype none
module pin_sync #(
    parameter int W = 1
) (
    input  wire logic         clk_sys,
    input  wire logic         reset,
    input  wire logic [W-1:0] raw,
    output logic      [W-1:0] stable
);
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            s1     <= {W{1'b0}};
            s2     <= {W{1'b0}};
            s3     <= {W{1'b0}};
            stable <= {W{1'b0}};
        end else begin
            s1     <= raw;
            s2     <= s1;
            s3     <= s2;
            stable <= (s3 & ~(s2 ^ s3)) | (stable & (s2 ^ s3));
        end
    end
endmodule
`default_nettype wire

// *** testbench/lldram_ctrl_model.sv ***
// lldram_ctrl_model.sv: behavioural memory controller that drives the link pins
// assumes: the bench calls its tasks; ck and the write strobe run free
`timescale 1ns/10ps
`default_nettype none
module lldram_ctrl_model #(
    parameter int BANK_CYCLE = 6
) (
    output logic        ck,
    output logic        chip_sel_n,
    output logic        write_en_n,
    output logic        refresh_n,
    output logic [2:0]  bank,
    output logic [19:0] addr,
    output logic [17:0] write_data,
    output logic        write_beat_mask,
    output logic        write_data_strobe
);
    time t_cmd;
    initial begin
        {ck, chip_sel_n, write_en_n, refresh_n, write_beat_mask, write_data_strobe} = 6'h1E;
        bank = 3'h0;
        addr = 20'h00000;
        write_data = 18'h00000;
    end
    always #200 ck = ~ck;
    // strobe lags ck a quarter period so data changed on ck edges sits centred
    always @(ck) write_data_strobe <= #100 ck;
    // op is {write_en_n, refresh_n}
    task automatic send(input logic [1:0] op, input logic [2:0] b, input logic [19:0] a, input bit mux);
        @(negedge ck);
        if (op == 2'h0) a[17:10] = 8'h00;
        chip_sel_n = 1'b0;
        {write_en_n, refresh_n} = op;
        bank = b;
        addr = (mux && op != 2'h2) ? {9'h000, a[10:0]} : a;
        @(posedge ck);
        t_cmd = $time;
        if (mux && op != 2'h2) begin
            @(negedge ck);
            chip_sel_n = 1'b1;
            bank = ~b;
            addr = {11'h7FF, a[19:11]};
            @(posedge ck);
        end
    endtask
    // released pins show a changing pattern, never the last value
    task automatic idle();
        @(negedge ck);
        chip_sel_n = 1'b1;
        {write_en_n, refresh_n} = ~{write_en_n, refresh_n};
        bank = ~bank;
        addr = ~addr;
    endtask
    task automatic wburst(input int wl, input int n, input logic [17:0] d[8], input logic [7:0] m);
        idle();
        repeat (wl) @(posedge ck);
        for (int k = 0; k < n; k++) begin
            if (k > 0) @(ck);
            write_data = d[k];
            write_beat_mask = m[k];
        end
        @(ck);
        write_data = ~write_data;
        write_beat_mask = ~write_beat_mask;
    endtask
    // a run lasts far less than one refresh interval
    task automatic refresh(input logic [2:0] b, input bit mux);
        send(2'h2, b, ~addr, mux);
        if (!mux) begin
            idle();
            repeat (BANK_CYCLE) @(posedge ck);
        end
    endtask
endmodule
`default_nettype wire

// *** testbench/tb_lldram_device.sv ***
// tb_lldram_device.sv: self-checking bench of the memory device
// assumes: controller model compiled first; design under logic/
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin errors++; $display("unexpected at %0t: %h not %h", $time, g, e); end end
module tb_lldram_device;
    logic        clk_sys, reset, ck, chip_sel_n, write_en_n, refresh_n, write_beat_mask, write_data_strobe;
    logic [2:0]  bank, b;
    logic [19:0] addr, a;
    logic [17:0] write_data, read_data;
    logic        read_data_oe_n, read_valid_flag, input_termination, vprev;
    logic [1:0]  read_data_strobe, bresp, rresp;
    logic [3:0]  awaddr, wstrb, araddr;
    logic [31:0] wdata, rdata, r;
    logic        awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
    logic [17:0] mem[256];
    logic [17:0] rq[$];
    logic        vq[$];
    time         rt[$];
    logic [12:0] cnt;
    int          errors, check_count, cycles, bl, rl;
    int          seed = 63655;
    bit          mux, term;

    lldram_device lldram_device_inst (.clk_sys, .reset, .ck, .chip_sel_n, .write_en_n, .refresh_n, .bank,
        .addr, .write_data, .write_beat_mask, .write_data_strobe, .read_data, .read_data_oe_n,
        .read_data_strobe, .read_valid_flag, .input_termination, .awaddr, .awvalid, .awready, .wdata,
        .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
        .rvalid, .rready);
    lldram_ctrl_model lldram_ctrl_model_inst (.ck, .chip_sel_n, .write_en_n, .refresh_n, .bank, .addr,
        .write_data, .write_beat_mask, .write_data_strobe);

    initial clk_sys = 1'b0;
    always #25 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 20000) begin
            $display("unexpected at %0t: run too long", $time);
            errors++;
            report_and_stop();
        end
    end
    // one sample per half ck cycle, mid-beat
    always @(read_data_strobe[0]) begin
        #100;
        if (read_data_oe_n === 1'b0) begin
            rq.push_back(read_data);
            rt.push_back($time);
            vq.push_back(vprev);
            `CHK(read_data_strobe[1], read_data_strobe[0])
            `CHK(input_termination, 1'b0)
        end
        vprev = read_valid_flag;
    end

    task automatic report_and_stop();
        if (errors == 0 && check_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic axw(input logic [3:0] ad, input logic [31:0] d, input logic [1:0] er);
        @(posedge clk_sys);
        awaddr <= ad;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clk_sys);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        bready <= 1'b0;
        `CHK(bresp, er)
    endtask
    task automatic axr(input logic [3:0] ad, output logic [31:0] d, input logic [1:0] er);
        @(posedge clk_sys);
        araddr <= ad;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clk_sys);
            if (arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        rready <= 1'b0;
        d = rdata;
        `CHK(rresp, er)
    endtask
    function automatic logic [7:0] loc(logic [2:0] bk, logic [19:0] ad, int k);
        return {bk, ad[4:0]} + 8'(k);
    endfunction
    task automatic do_write(input logic [2:0] bk, input logic [19:0] ad, input logic [7:0] m);
        logic [17:0] d[8];
        for (int k = 0; k < 8; k++) d[k] = 18'($random(seed));
        for (int k = 0; k < bl; k++) if (!m[k]) mem[loc(bk, ad, k)] = d[k];
        lldram_ctrl_model_inst.send(2'h1, bk, ad, mux);
        lldram_ctrl_model_inst.wburst(rl + 1, bl, d, m);
        repeat (2) @(posedge ck);
    endtask
    task automatic do_read(input logic [2:0] bk, input logic [19:0] ad, input int n);
        logic [17:0] ex[$];
        time t0;
        for (int j = 0; j < n; j++) begin
            lldram_ctrl_model_inst.send(2'h3, bk, ad + 20'(j * bl), mux);
            if (j == 0) t0 = lldram_ctrl_model_inst.t_cmd;
            for (int k = 0; k < bl; k++) ex.push_back(mem[loc(bk, ad, j * bl + k)]);
        end
        lldram_ctrl_model_inst.idle();
        repeat (rl + bl + 6) @(posedge ck);
        `CHK(rq.size(), ex.size())
        foreach (ex[k]) begin
            `CHK(rq[k], ex[k])
            `CHK(vq[k], 1'b1)
            `CHK(rt[k] - rt[0], time'(200 * k))
        end
        `CHK((rt[0] - t0 + 200) / 400, time'(rl + mux + 1))
        `CHK(read_data_oe_n, 1'b1)
        `CHK(read_valid_flag, 1'b0)
        `CHK(input_termination, term)
        rq.delete();
        rt.delete();
        vq.delete();
    endtask
    task automatic cfg(input logic [19:0] ad);
        lldram_ctrl_model_inst.send(2'h0, 3'h0, ad, mux);
        lldram_ctrl_model_inst.idle();
        repeat (4) @(posedge ck);
        bl = ad[4] ? 8 : (ad[3] ? 4 : 2);
        term = ad[9];
        mux = ad[5];
        `CHK(input_termination, term)
    endtask

    initial begin
        {reset, awvalid, wvalid, bready, arvalid, rready} = 6'h20;
        {awaddr, araddr, wdata, wstrb} = {8'h00, 32'h0000_0000, 4'hF};
        {bl, rl, mux, term} = {32'd2, 32'd4, 2'b00};
        repeat (16) @(posedge clk_sys);
        reset <= 1'b0;
        @(posedge clk_sys);
        `CHK(read_data_oe_n, 1'b1)
        axr(4'h0, r, 2'h0);
        `CHK(r, 32'h0000_0004)
        axr(4'h8, r, 2'h2);
        axw(4'hC, 32'hFFFF_FFFF, 2'h2);
        axw(4'h4, 32'h0000_0000, 2'h0);
        for (int i = 0; i < 4; i++) begin
            b = 3'($random(seed));
            a = 20'($unsigned($random(seed)) % 16);
            rl = 2 + $unsigned($random(seed)) % 4;
            axw(4'h0, {25'h0, b, 4'(rl)}, 2'h0);
            do_write(b, a, 8'h00);
            do_write(b, a, 8'($random(seed)));
            do_read(b, a, 1 + i % 2);
        end
        rl = 4;
        axw(4'h0, 32'h0000_0054, 2'h0);
        axr(4'h4, r, 2'h0);
        cnt = r[28:16];
        lldram_ctrl_model_inst.refresh(3'h5, 1'b0);
        lldram_ctrl_model_inst.refresh(3'h5, 1'b0);
        axr(4'h4, r, 2'h0);
        `CHK(r[28:16], cnt + 13'h0002)
        cfg(20'hFFE08);
        axr(4'h4, r, 2'h0);
        `CHK(r[5:0], 6'h05)
        do_write(3'h2, 20'h00003, 8'h02);
        do_read(3'h2, 20'h00003, 1);
        cfg(20'h00228);
        axr(4'h4, r, 2'h0);
        `CHK(r[5:0], 6'h0D)
        do_write(3'h6, 20'h00005, 8'h00);
        do_write(3'h6, 20'h00005, 8'h09);
        lldram_ctrl_model_inst.refresh(3'h1, 1'b1);
        do_read(3'h6, 20'h00005, 2);
        cfg(20'h00230);
        axw(4'h0, 32'h0000_0030, 2'h0);
        rl = 1;
        do_write(3'h3, 20'h00001, 8'h81);
        do_read(3'h3, 20'h00001, 1);
        report_and_stop();
    end
endmodule
`default_nettype wire
